// ### rtl/dmr_register_map.sv
// holding-register map of a motor drive: monitors, keypad settings and basic setup
// assumes single-cycle requests from a serial-bus front end on CLK and monitor
// values from drive logic on CLK; the input terminal levels come from pins
`timescale 1ns/100ps
`include "dmr_regs.svh"

module dmr_register_map #(
    parameter int SETTLE_CYCLES = `DMR_SETTLE_MS * `DMR_CLK_KHZ
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    output logic             REG_ACK,
    output logic             REG_EXC,
    output logic      [7:0]  REG_EXC_CODE,

    input  wire logic [31:0] OUTPUT_FREQ,
    input  wire logic [15:0] OUTPUT_CURRENT,
    input  wire logic [1:0]  ROTATION_DIRECTION,
    input  wire logic [31:0] PROCESS_FEEDBACK,
    input  wire logic [4:0]  INPUT_TERMINAL_PINS,
    input  wire logic [1:0]  OUTPUT_TERMINAL_STATE,
    input  wire logic [31:0] SCALED_FREQ,
    input  wire logic [15:0] OUTPUT_VOLTAGE,
    input  wire logic [15:0] OUTPUT_POWER,
    input  wire logic [31:0] ENERGY_TOTAL,
    input  wire logic [31:0] RUN_HOURS,
    input  wire logic [31:0] POWERED_HOURS,
    input  wire logic [15:0] HEATSINK_TEMPERATURE,
    input  wire logic [15:0] DC_BUS_VOLTAGE,
    input  wire logic [15:0] THERMAL_LOAD_LEVEL,

    output logic      [31:0] ACCEL_TIME,
    output logic      [31:0] DECEL_TIME,
    output logic             KEYPAD_RUN_DIRECTION,
    output logic      [3:0]  FREQ_REFERENCE_SOURCE,
    output logic      [1:0]  RUN_COMMAND_SOURCE,
    output logic      [15:0] BASE_FREQUENCY,
    output logic      [15:0] MAXIMUM_FREQUENCY,
    output logic      [15:0] ANALOG_START_FREQ,
    output logic      [15:0] ANALOG_END_FREQ,
    output logic      [6:0]  ANALOG_START_LEVEL,
    output logic      [6:0]  ANALOG_END_LEVEL,
    output logic             ANALOG_START_BEHAVIOUR,
    output logic      [4:0]  ANALOG_INPUT_FILTER,
    output logic             SETTINGS_SETTLED
);

    // address classes, shared by the read and write paths
    function automatic dmr_pkg::dmr_class_t addr_class(input logic [15:0] a);
        case (a)
            `DMR_A_OFREQ_HI, `DMR_A_OFREQ_LO, `DMR_A_OCURRENT, `DMR_A_ROTATION,
            `DMR_A_FEEDBK_HI, `DMR_A_FEEDBK_LO, `DMR_A_IN_TERM, `DMR_A_OUT_TERM,
            `DMR_A_SCALED_HI, `DMR_A_SCALED_LO, `DMR_A_OVOLTAGE, `DMR_A_OPOWER,
            `DMR_A_ENERGY_HI, `DMR_A_ENERGY_LO, `DMR_A_RUNHRS_HI, `DMR_A_RUNHRS_LO,
            `DMR_A_PWRHRS_HI, `DMR_A_PWRHRS_LO, `DMR_A_HEATSINK, `DMR_A_DCBUS,
            `DMR_A_THERMAL: begin
                return dmr_pkg::DMR_RO;
            end
            `DMR_A_ACCEL_HI, `DMR_A_ACCEL_LO, `DMR_A_DECEL_HI, `DMR_A_DECEL_LO,
            `DMR_A_KEYDIR, `DMR_A_FREQSRC, `DMR_A_RUNSRC, `DMR_A_BASEFREQ,
            `DMR_A_MAXFREQ, `DMR_A_AN_SFREQ, `DMR_A_AN_EFREQ, `DMR_A_AN_SLVL,
            `DMR_A_AN_ELVL, `DMR_A_AN_BEHAV, `DMR_A_AN_FILT: begin
                return dmr_pkg::DMR_RW;
            end
            default: begin
                return dmr_pkg::DMR_NONE;
            end
        endcase
    endfunction

    // out-of-range monitor values read as the ceiling, never wrap
    function automatic logic [31:0] clamp_u32(input logic [31:0] v, input logic [31:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    dmr_pkg::dmr_word_t  accel_hi;
    dmr_pkg::dmr_word_t  accel_lo;
    dmr_pkg::dmr_word_t  decel_hi;
    dmr_pkg::dmr_word_t  decel_lo;
    dmr_pkg::dmr_word_t  key_dir;
    dmr_pkg::dmr_word_t  freq_src;
    dmr_pkg::dmr_word_t  run_src;
    dmr_pkg::dmr_word_t  base_freq;
    dmr_pkg::dmr_word_t  max_freq;
    dmr_pkg::dmr_word_t  an_sfreq;
    dmr_pkg::dmr_word_t  an_efreq;
    dmr_pkg::dmr_word_t  an_slvl;
    dmr_pkg::dmr_word_t  an_elvl;
    dmr_pkg::dmr_word_t  an_behav;
    dmr_pkg::dmr_word_t  an_filt;

    dmr_pkg::dmr_word_t  rd_word;
    dmr_pkg::dmr_class_t req_class;
    logic                req;
    logic                is_write;
    logic                value_ok;
    logic                wr_commit;
    logic                req_ok;

    logic [31:0]         ofreq_c;
    logic [31:0]         feedbk_c;
    logic [31:0]         scaled_c;
    logic [31:0]         energy_c;
    logic [31:0]         runhrs_c;
    logic [31:0]         pwrhrs_c;
    logic [15:0]         temp_c;

    logic [4:0]          pin_ff1;
    logic [4:0]          pin_ff2;
    logic [4:0]          pin_ff3;
    logic [4:0]          in_term;
    logic [22:0]         settle_cnt;

    // a write wins over a simultaneous read
    assign req       = REG_WR | REG_RD;
    assign is_write  = REG_WR;
    assign req_class = addr_class(REG_ADDR);
    assign req_ok    = is_write ? (req_class == dmr_pkg::DMR_RW) && value_ok
                                : (req_class != dmr_pkg::DMR_NONE);
    assign wr_commit = req && is_write && req_ok;

    // value checks; a pair is judged as the whole 32-bit quantity it forms
    always_comb begin
        value_ok = 1'b0;
        case (REG_ADDR)
            `DMR_A_ACCEL_HI: value_ok = {REG_WDATA, accel_lo} <= `DMR_TIME_MAX;
            `DMR_A_ACCEL_LO: value_ok = {accel_hi, REG_WDATA} <= `DMR_TIME_MAX;
            `DMR_A_DECEL_HI: value_ok = {REG_WDATA, decel_lo} <= `DMR_TIME_MAX;
            `DMR_A_DECEL_LO: value_ok = {decel_hi, REG_WDATA} <= `DMR_TIME_MAX;
            `DMR_A_KEYDIR:   value_ok = REG_WDATA <= 16'h0001;
            `DMR_A_FREQSRC:  value_ok = (REG_WDATA <= `DMR_SRC_SERIAL) || (REG_WDATA == `DMR_SRC_COMPUTED);
            `DMR_A_RUNSRC:   value_ok = (REG_WDATA >= `DMR_SRC_TERMINAL) && (REG_WDATA <= `DMR_SRC_SERIAL);
            `DMR_A_BASEFREQ: value_ok = (REG_WDATA >= `DMR_FREQ_LOW) && (REG_WDATA <= max_freq);
            // lowering the maximum below the base would strand the base setting
            `DMR_A_MAXFREQ:  value_ok = (REG_WDATA >= `DMR_FREQ_LOW) && (REG_WDATA <= `DMR_FREQ_HIGH)
                                        && (REG_WDATA >= base_freq);
            `DMR_A_AN_SFREQ: value_ok = REG_WDATA <= `DMR_AN_FREQ_MAX;
            `DMR_A_AN_EFREQ: value_ok = REG_WDATA <= `DMR_AN_FREQ_MAX;
            `DMR_A_AN_SLVL:  value_ok = REG_WDATA <= an_elvl;
            `DMR_A_AN_ELVL:  value_ok = (REG_WDATA >= an_slvl) && (REG_WDATA <= `DMR_LEVEL_MAX);
            `DMR_A_AN_BEHAV: value_ok = REG_WDATA <= 16'h0001;
            `DMR_A_AN_FILT:  value_ok = (REG_WDATA >= 16'h0001) && (REG_WDATA <= `DMR_FILT_MAX);
            default:         value_ok = 1'b0;
        endcase
    end

    // settings storage; nothing changes unless the whole write is legal
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            accel_hi <= 16'(`DMR_RST_TIME >> 16);
            accel_lo <= 16'(`DMR_RST_TIME);
            decel_hi <= 16'(`DMR_RST_TIME >> 16);
            decel_lo <= 16'(`DMR_RST_TIME);
            key_dir  <= `DMR_RST_KEYDIR;
            freq_src <= `DMR_RST_FREQSRC;
            run_src  <= `DMR_RST_RUNSRC;
            base_freq <= `DMR_RST_BASEFREQ;
            max_freq <= `DMR_RST_MAXFREQ;
            an_sfreq <= `DMR_RST_AN_SFREQ;
            an_efreq <= `DMR_RST_AN_EFREQ;
            an_slvl  <= `DMR_RST_AN_SLVL;
            an_elvl  <= `DMR_RST_AN_ELVL;
            an_behav <= `DMR_RST_AN_BEHAV;
            an_filt  <= `DMR_RST_AN_FILT;
        end else if (wr_commit) begin
            case (REG_ADDR)
                `DMR_A_ACCEL_HI: accel_hi <= REG_WDATA;
                `DMR_A_ACCEL_LO: accel_lo <= REG_WDATA;
                `DMR_A_DECEL_HI: decel_hi <= REG_WDATA;
                `DMR_A_DECEL_LO: decel_lo <= REG_WDATA;
                `DMR_A_KEYDIR:   key_dir <= REG_WDATA;
                `DMR_A_FREQSRC:  freq_src <= REG_WDATA;
                `DMR_A_RUNSRC:   run_src <= REG_WDATA;
                `DMR_A_BASEFREQ: base_freq <= REG_WDATA;
                `DMR_A_MAXFREQ:  max_freq <= REG_WDATA;
                `DMR_A_AN_SFREQ: an_sfreq <= REG_WDATA;
                `DMR_A_AN_EFREQ: an_efreq <= REG_WDATA;
                `DMR_A_AN_SLVL:  an_slvl <= REG_WDATA;
                `DMR_A_AN_ELVL:  an_elvl <= REG_WDATA;
                `DMR_A_AN_BEHAV: an_behav <= REG_WDATA;
                `DMR_A_AN_FILT:  an_filt <= REG_WDATA;
                default: begin
                end
            endcase
        end
    end

    // settings straight to the drive logic from the storage flops
    assign ACCEL_TIME             = {accel_hi, accel_lo};
    assign DECEL_TIME             = {decel_hi, decel_lo};
    assign KEYPAD_RUN_DIRECTION   = key_dir[0];
    assign FREQ_REFERENCE_SOURCE  = freq_src[3:0];
    assign RUN_COMMAND_SOURCE     = run_src[1:0];
    assign BASE_FREQUENCY         = base_freq;
    assign MAXIMUM_FREQUENCY      = max_freq;
    assign ANALOG_START_FREQ      = an_sfreq;
    assign ANALOG_END_FREQ        = an_efreq;
    assign ANALOG_START_LEVEL     = an_slvl[6:0];
    assign ANALOG_END_LEVEL       = an_elvl[6:0];
    assign ANALOG_START_BEHAVIOUR = an_behav[0];
    assign ANALOG_INPUT_FILTER    = an_filt[4:0];

    // terminal pins: three flops, a bit moves only once stages two and three agree
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_ff1 <= 5'h00;
            pin_ff2 <= 5'h00;
            pin_ff3 <= 5'h00;
            in_term <= 5'h00;
        end else begin
            pin_ff1 <= INPUT_TERMINAL_PINS;
            pin_ff2 <= pin_ff1;
            pin_ff3 <= pin_ff2;
            in_term <= (~(pin_ff2 ^ pin_ff3) & pin_ff3) | ((pin_ff2 ^ pin_ff3) & in_term);
        end
    end

    // clamped monitor quantities
    assign ofreq_c  = clamp_u32(OUTPUT_FREQ, `DMR_OFREQ_MAX);
    assign feedbk_c = clamp_u32(PROCESS_FEEDBACK, `DMR_FEEDBK_MAX);
    assign scaled_c = clamp_u32(SCALED_FREQ, `DMR_SCALED_MAX);
    assign energy_c = clamp_u32(ENERGY_TOTAL, `DMR_ENERGY_MAX);
    assign runhrs_c = clamp_u32(RUN_HOURS, `DMR_HOURS_MAX);
    assign pwrhrs_c = clamp_u32(POWERED_HOURS, `DMR_HOURS_MAX);
    // signed compare keeps negative readings down to -200 intact
    assign temp_c   = ($signed(HEATSINK_TEMPERATURE) < $signed(`DMR_TEMP_MIN)) ? `DMR_TEMP_MIN :
                      ($signed(HEATSINK_TEMPERATURE) > $signed(`DMR_TEMP_MAX)) ? `DMR_TEMP_MAX :
                      HEATSINK_TEMPERATURE;

    // read multiplexer; high half of each pair sits at the lower address
    always_comb begin
        rd_word = 16'h0000;
        case (REG_ADDR)
            `DMR_A_OFREQ_HI:  rd_word = ofreq_c[31:16];
            `DMR_A_OFREQ_LO:  rd_word = ofreq_c[15:0];
            `DMR_A_OCURRENT:  rd_word = OUTPUT_CURRENT;
            `DMR_A_ROTATION:  rd_word = (ROTATION_DIRECTION == 2'h3) ? 16'h0000 : {14'h0000, ROTATION_DIRECTION};
            `DMR_A_FEEDBK_HI: rd_word = feedbk_c[31:16];
            `DMR_A_FEEDBK_LO: rd_word = feedbk_c[15:0];
            `DMR_A_IN_TERM:   rd_word = {11'h000, in_term};
            `DMR_A_OUT_TERM:  rd_word = {14'h0000, OUTPUT_TERMINAL_STATE};
            `DMR_A_SCALED_HI: rd_word = scaled_c[31:16];
            `DMR_A_SCALED_LO: rd_word = scaled_c[15:0];
            `DMR_A_OVOLTAGE:  rd_word = OUTPUT_VOLTAGE;
            `DMR_A_OPOWER:    rd_word = OUTPUT_POWER;
            `DMR_A_ENERGY_HI: rd_word = energy_c[31:16];
            `DMR_A_ENERGY_LO: rd_word = energy_c[15:0];
            `DMR_A_RUNHRS_HI: rd_word = runhrs_c[31:16];
            `DMR_A_RUNHRS_LO: rd_word = runhrs_c[15:0];
            `DMR_A_PWRHRS_HI: rd_word = pwrhrs_c[31:16];
            `DMR_A_PWRHRS_LO: rd_word = pwrhrs_c[15:0];
            `DMR_A_HEATSINK:  rd_word = temp_c;
            `DMR_A_DCBUS:     rd_word = DC_BUS_VOLTAGE;
            `DMR_A_THERMAL:   rd_word = THERMAL_LOAD_LEVEL;
            `DMR_A_ACCEL_HI:  rd_word = accel_hi;
            `DMR_A_ACCEL_LO:  rd_word = accel_lo;
            `DMR_A_DECEL_HI:  rd_word = decel_hi;
            `DMR_A_DECEL_LO:  rd_word = decel_lo;
            `DMR_A_KEYDIR:    rd_word = key_dir;
            `DMR_A_FREQSRC:   rd_word = freq_src;
            `DMR_A_RUNSRC:    rd_word = run_src;
            `DMR_A_BASEFREQ:  rd_word = base_freq;
            `DMR_A_MAXFREQ:   rd_word = max_freq;
            `DMR_A_AN_SFREQ:  rd_word = an_sfreq;
            `DMR_A_AN_EFREQ:  rd_word = an_efreq;
            `DMR_A_AN_SLVL:   rd_word = an_slvl;
            `DMR_A_AN_ELVL:   rd_word = an_elvl;
            `DMR_A_AN_BEHAV:  rd_word = an_behav;
            `DMR_A_AN_FILT:   rd_word = an_filt;
            default:          rd_word = 16'h0000;
        endcase
    end

    // one answer per request, one cycle later: either ack or exception
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA    <= 16'h0000;
            REG_ACK      <= 1'b0;
            REG_EXC      <= 1'b0;
            REG_EXC_CODE <= 8'h00;
        end else begin
            REG_ACK <= req && req_ok;
            REG_EXC <= req && !req_ok;
            if (req) begin
                REG_RDATA    <= (!is_write && req_ok) ? rd_word : 16'h0000;
                REG_EXC_CODE <= req_ok ? 8'h00 :
                                (is_write && req_class == dmr_pkg::DMR_RW) ? `DMR_EXC_VALUE : `DMR_EXC_ADDR;
            end
        end
    end

    // settle timer: restarts on every accepted write, lets the drive gate run commands
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            settle_cnt <= 23'h000000;
        end else if (wr_commit) begin
            settle_cnt <= SETTLE_CYCLES[22:0];
        end else if (settle_cnt != 23'h000000) begin
            settle_cnt <= settle_cnt - 23'h000001;
        end
    end

    assign SETTINGS_SETTLED = (settle_cnt == 23'h000000);

endmodule

// ### rtl/dmr_regs.svh
// register offsets, limits, reset values and timing counts of the drive register map
// assumes inclusion by the single top module and the package-free constant style
`ifndef DMR_REGS_SVH
`define DMR_REGS_SVH

// monitoring group, read only
`define DMR_A_OFREQ_HI    16'h1001
`define DMR_A_OFREQ_LO    16'h1002
`define DMR_A_OCURRENT    16'h1003
`define DMR_A_ROTATION    16'h1004
`define DMR_A_FEEDBK_HI   16'h1005
`define DMR_A_FEEDBK_LO   16'h1006
`define DMR_A_IN_TERM     16'h1007
`define DMR_A_OUT_TERM    16'h1008
`define DMR_A_SCALED_HI   16'h1009
`define DMR_A_SCALED_LO   16'h100A
`define DMR_A_OVOLTAGE    16'h1011
`define DMR_A_OPOWER      16'h1012
`define DMR_A_ENERGY_HI   16'h1013
`define DMR_A_ENERGY_LO   16'h1014
`define DMR_A_RUNHRS_HI   16'h1015
`define DMR_A_RUNHRS_LO   16'h1016
`define DMR_A_PWRHRS_HI   16'h1017
`define DMR_A_PWRHRS_LO   16'h1018
`define DMR_A_HEATSINK    16'h1019
`define DMR_A_DCBUS       16'h1026
`define DMR_A_THERMAL     16'h1028

// settings, read/write
`define DMR_A_ACCEL_HI    16'h1103
`define DMR_A_ACCEL_LO    16'h1104
`define DMR_A_DECEL_HI    16'h1105
`define DMR_A_DECEL_LO    16'h1106
`define DMR_A_KEYDIR      16'h1107
`define DMR_A_FREQSRC     16'h1201
`define DMR_A_RUNSRC      16'h1202
`define DMR_A_BASEFREQ    16'h1203
`define DMR_A_MAXFREQ     16'h1204
`define DMR_A_AN_SFREQ    16'h120C
`define DMR_A_AN_EFREQ    16'h120E
`define DMR_A_AN_SLVL     16'h120F
`define DMR_A_AN_ELVL     16'h1210
`define DMR_A_AN_BEHAV    16'h1211
`define DMR_A_AN_FILT     16'h1212

// value limits
`define DMR_OFREQ_MAX     32'h00009C40
`define DMR_FEEDBK_MAX    32'h00018696
`define DMR_SCALED_MAX    32'h00061A58
`define DMR_ENERGY_MAX    32'h00989298
`define DMR_HOURS_MAX     32'h000F41DC
`define DMR_TIME_MAX      32'h00057E40
`define DMR_TEMP_MIN      16'hFF38
`define DMR_TEMP_MAX      16'h05DC
`define DMR_FREQ_LOW      16'h012C
`define DMR_FREQ_HIGH     16'h0FA0
`define DMR_AN_FREQ_MAX   16'h9C40
`define DMR_LEVEL_MAX     16'h0064
`define DMR_FILT_MAX      16'h001F
`define DMR_SRC_POT       16'h0000
`define DMR_SRC_TERMINAL  16'h0001
`define DMR_SRC_OPERATOR  16'h0002
`define DMR_SRC_SERIAL    16'h0003
`define DMR_SRC_COMPUTED  16'h000A

// exception codes of the serial bus
`define DMR_EXC_ADDR      8'h02
`define DMR_EXC_VALUE     8'h03

// reset values of the settings
`define DMR_RST_TIME      32'h000003E8
`define DMR_RST_KEYDIR    16'h0000
`define DMR_RST_FREQSRC   16'h0000
`define DMR_RST_RUNSRC    16'h0001
`define DMR_RST_BASEFREQ  16'h0258
`define DMR_RST_MAXFREQ   16'h0258
`define DMR_RST_AN_SFREQ  16'h0000
`define DMR_RST_AN_EFREQ  16'h0000
`define DMR_RST_AN_SLVL   16'h0000
`define DMR_RST_AN_ELVL   16'h0064
`define DMR_RST_AN_BEHAV  16'h0001
`define DMR_RST_AN_FILT   16'h0008

// settle time after a setting change
`define DMR_SETTLE_MS     40
`define DMR_CLK_KHZ       100000

`endif

// ### rtl/dmr_pkg.sv
// types shared by the drive register map
// assumes nothing beyond a SystemVerilog compiler
package dmr_pkg;
    typedef logic [15:0] dmr_word_t;
    typedef enum logic [1:0] {
        DMR_NONE,
        DMR_RO,
        DMR_RW
    } dmr_class_t;
endpackage

// ### test/dmr_master.sv
// bus master model, one request at a time
// assumes each request is answered one cycle later
`timescale 1ns/100ps
module dmr_master (
    input  wire logic        CLK,
    output logic      [15:0] REG_ADDR,
    output logic      [15:0] REG_WDATA,
    output logic             REG_WR,
    output logic             REG_RD,
    input  wire logic [15:0] REG_RDATA,
    input  wire logic        REG_ACK,
    input  wire logic        REG_EXC,
    input  wire logic [7:0]  REG_EXC_CODE
);
    logic [15:0] rdata;
    logic [7:0]  code;

    initial {REG_ADDR, REG_WDATA, REG_WR, REG_RD} = '0;

    // drive after a falling edge, read the answer a cycle on
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = wr;
        REG_RD = !wr;
        @(negedge CLK);
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        // idle lines show the inverse of the last request
        REG_ADDR = ~a;
        REG_WDATA = ~d;
        rdata = REG_RDATA;
        code = (REG_ACK ^ REG_EXC) ? REG_EXC_CODE : 8'hFF; // none or both: no match
    endtask
endmodule

// ### test/dmr_register_map_monitor.sv
// bus protocol and setting range checks
// assumes one clock, reset active high
`timescale 1ns/100ps
module dmr_register_map_monitor (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_ACK,
    input wire logic        REG_EXC,
    input wire logic [7:0]  REG_EXC_CODE,
    input wire logic [1:0]  ROTATION_DIRECTION,
    input wire logic        KEYPAD_RUN_DIRECTION,
    input wire logic [3:0]  FREQ_REFERENCE_SOURCE,
    input wire logic [1:0]  RUN_COMMAND_SOURCE,
    input wire logic [15:0] BASE_FREQUENCY,
    input wire logic [15:0] MAXIMUM_FREQUENCY,
    input wire logic [6:0]  ANALOG_START_LEVEL,
    input wire logic [6:0]  ANALOG_END_LEVEL,
    input wire logic [4:0]  ANALOG_INPUT_FILTER
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic req;
    assign req = REG_WR | REG_RD;

    // one answer per request, none when idle
    AST_ONE_ANSWER: assert property (req |=> REG_ACK != REG_EXC) else $error("no single answer");
    AST_IDLE_QUIET: assert property (!req |=> !REG_ACK && !REG_EXC) else $error("stray answer");
    AST_ACK_CODE: assert property (REG_ACK |-> REG_EXC_CODE == 8'h00) else $error("success with code");
    // writes to 0x1001-0x1028 and reads of the holes 0x100B-0x1010 and 0x1029-0x1102 refused
    AST_RO_WRITE: assert property (REG_WR && REG_ADDR inside {[16'h1001:16'h1028]}
        |=> REG_EXC && REG_EXC_CODE == 8'h02) else $error("monitor write taken");
    AST_HOLE_READ: assert property (REG_RD && !REG_WR && REG_ADDR inside {[16'h100B:16'h1010], [16'h1029:16'h1102]}
        |=> REG_EXC && REG_EXC_CODE == 8'h02) else $error("reserved read taken");
    AST_ROT_READ: assert property (REG_RD && !REG_WR && REG_ADDR == 16'h1004 && ROTATION_DIRECTION != 2'h3
        |=> REG_ACK && REG_RDATA == {14'h0000, $past(ROTATION_DIRECTION)}) else $error("rotation read");
    AST_KEYDIR: assert property (REG_WR && REG_ADDR == 16'h1107 && REG_WDATA <= 16'h0001
        |=> REG_ACK && KEYPAD_RUN_DIRECTION == $past(REG_WDATA[0])) else $error("keypad direction");
    // settings stay in their legal sets
    AST_FREQ_SRC: assert property (FREQ_REFERENCE_SOURCE inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hA})
        else $error("frequency source");
    AST_RUN_SRC: assert property (RUN_COMMAND_SOURCE != 2'h0) else $error("run source");
    AST_FREQ_ORDER: assert property (BASE_FREQUENCY >= 16'h012C && BASE_FREQUENCY <= MAXIMUM_FREQUENCY
        && MAXIMUM_FREQUENCY <= 16'h0FA0) else $error("base or maximum");
    AST_LEVELS: assert property (ANALOG_START_LEVEL <= ANALOG_END_LEVEL && ANALOG_END_LEVEL <= 7'h64)
        else $error("analog levels");
    AST_FILTER: assert property (ANALOG_INPUT_FILTER != 5'h00) else $error("filter zero");
    cover property (REG_WR ##1 REG_ACK);
    cover property (REG_WR ##1 REG_EXC && REG_EXC_CODE == 8'h03);
    cover property (REG_RD ##1 REG_EXC && REG_EXC_CODE == 8'h02);
endmodule

bind dmr_register_map dmr_register_map_monitor u_mon (.*);

// ### test/drive_modbus_register_map_tb.sv
// self-checking bench of the drive register map
// assumes a 20-cycle settle time and still monitors
`timescale 1ns/100ps
module drive_modbus_register_map_tb;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        REG_WR, REG_RD, REG_ACK, REG_EXC, KEYPAD_RUN_DIRECTION, ANALOG_START_BEHAVIOUR, SETTINGS_SETTLED;
    logic [1:0]  ROTATION_DIRECTION, OUTPUT_TERMINAL_STATE, RUN_COMMAND_SOURCE;
    logic [3:0]  FREQ_REFERENCE_SOURCE;
    logic [4:0]  INPUT_TERMINAL_PINS, ANALOG_INPUT_FILTER;
    logic [6:0]  ANALOG_START_LEVEL, ANALOG_END_LEVEL;
    logic [7:0]  REG_EXC_CODE, ec;
    logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, OUTPUT_CURRENT, OUTPUT_VOLTAGE, OUTPUT_POWER, HEATSINK_TEMPERATURE;
    logic [15:0] DC_BUS_VOLTAGE, THERMAL_LOAD_LEVEL, BASE_FREQUENCY, MAXIMUM_FREQUENCY, ANALOG_START_FREQ, d;
    logic [15:0] ANALOG_END_FREQ, shadow [logic [15:0]];
    logic [31:0] OUTPUT_FREQ, PROCESS_FEEDBACK, SCALED_FREQ, ENERGY_TOTAL, RUN_HOURS, POWERED_HOURS, rnd;
    logic [31:0] ACCEL_TIME, DECEL_TIME;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [31:0] rst_tab [15] = '{32'h11030000, 32'h110403E8, 32'h11050000, 32'h110603E8, 32'h11070000,
        32'h12010000, 32'h12020001, 32'h12030258, 32'h12040258, 32'h120C0000, 32'h120E0000, 32'h120F0000,
        32'h12100064, 32'h12110001, 32'h12120008};
    // address, data, code; one or both sides of each limit except the decel time, which is not written
    logic [39:0] wr_tab [36] = '{40'h1107000100, 40'h1107000203, 40'h1201000000, 40'h1201000100,
        40'h1201000200, 40'h1201000300, 40'h1201000403, 40'h1201000A00, 40'h1202000003, 40'h1202000300,
        40'h1202000200, 40'h12040FA103, 40'h12040FA000, 40'h12030FA000, 40'h12040F9F03, 40'h1203012B03,
        40'h1203012C00, 40'h1204012C00, 40'h120C9C4103, 40'h120C9C4000, 40'h120E9C4000, 40'h1210006503,
        40'h120F006400, 40'h1210006303, 40'h120F000000, 40'h1210000000, 40'h1211000203, 40'h1211000000,
        40'h1212000003, 40'h1212001F00, 40'h1212002003, 40'h11047E4000, 40'h1103000500, 40'h11047E4103,
        40'h1001000502, 40'h1019000502};
    logic [15:0] hole_tab [5] = '{16'h100B, 16'h1027, 16'h1102, 16'h1200, 16'h1213};

    dmr_register_map #(.SETTLE_CYCLES(20)) DUT (.*);
    dmr_master u_mst (.*);

    always #5 CLK = ~CLK;

    // ceiling well above the run length
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
    endfunction
    function automatic logic [31:0] clip(input logic [31:0] v, input logic [31:0] m);
        return (v > m) ? m : v;
    endfunction
    function automatic logic [15:0] tclip(input logic [15:0] t);
        return ($signed(t) < -16'sd200) ? 16'hFF38 : ($signed(t) > 16'sd1500) ? 16'h05DC : t;
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        u_mst.xfer(1'b0, a, 16'h0000);
        chk8(u_mst.code, 8'h00);
        chk16(u_mst.rdata, e);
    endtask
    // high word lives at the lower address
    task automatic rd32(input logic [15:0] a, input logic [31:0] e);
        rd(a, e[31:16]);
        rd(a + 16'h0001, e[15:0]);
    endtask
    // write, check the code, read back the kept value of a shadowed setting
    task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic [7:0] e);
        u_mst.xfer(1'b1, a, v);
        chk8(u_mst.code, e);
        if (e == 8'h00 && shadow.exists(a)) shadow[a] = v;
        if (shadow.exists(a)) rd(a, shadow[a]);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        {OUTPUT_FREQ, OUTPUT_CURRENT, ROTATION_DIRECTION, PROCESS_FEEDBACK, INPUT_TERMINAL_PINS, OUTPUT_TERMINAL_STATE,
         SCALED_FREQ, OUTPUT_VOLTAGE, OUTPUT_POWER, ENERGY_TOTAL, RUN_HOURS, POWERED_HOURS, HEATSINK_TEMPERATURE,
         DC_BUS_VOLTAGE, THERMAL_LOAD_LEVEL} = '0;
        rnd = 32'hF3FD;
        repeat (16) @(negedge CLK);
        SYS_RST = 1'b0;
        foreach (rst_tab[i]) begin
            shadow[rst_tab[i][31:16]] = rst_tab[i][15:0];
            rd(rst_tab[i][31:16], rst_tab[i][15:0]);
        end
        $display("reset values done");
        // pass 0 saturates, pass 1 puts the heatsink at its ceiling, later passes random
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            @(negedge CLK);
            {OUTPUT_FREQ, PROCESS_FEEDBACK, SCALED_FREQ} = (k == 0) ? '1 : {rnd >> 15, rnd >> 14, rnd >> 12};
            {ENERGY_TOTAL, RUN_HOURS, POWERED_HOURS} = (k == 0) ? '1 : {rnd >> 8, rnd >> 12, rnd >> 11};
            {OUTPUT_CURRENT, OUTPUT_VOLTAGE, OUTPUT_POWER, DC_BUS_VOLTAGE, THERMAL_LOAD_LEVEL} = {5{rnd[19:4]}};
            HEATSINK_TEMPERATURE = (k == 0) ? 16'h8000 : (k == 1) ? 16'h05DC : {{6{rnd[9]}}, rnd[9:0]};
            {ROTATION_DIRECTION, INPUT_TERMINAL_PINS, OUTPUT_TERMINAL_STATE} = {k[1:0], rnd[6:0]};
            repeat (5) @(negedge CLK);
            rd32(16'h1005, clip(PROCESS_FEEDBACK, 32'd99990));
            rd32(16'h1009, clip(SCALED_FREQ, 32'd399960));
            rd32(16'h1015, clip(RUN_HOURS, 32'd999900));
            rd32(16'h1017, clip(POWERED_HOURS, 32'd999900));
            rd(16'h1004, (ROTATION_DIRECTION == 2'h3) ? 16'h0000 : {14'h0000, ROTATION_DIRECTION});
            rd(16'h1007, {11'h000, INPUT_TERMINAL_PINS});
            rd(16'h1008, {14'h0000, OUTPUT_TERMINAL_STATE});
            rd(16'h1019, tclip(HEATSINK_TEMPERATURE));
            rd(16'h1026, DC_BUS_VOLTAGE);
        end
        $display("monitor reads done");
        foreach (wr_tab[i]) wr(wr_tab[i][39:24], wr_tab[i][23:8], wr_tab[i][7:0]);
        foreach (hole_tab[i]) begin
            u_mst.xfer(1'b0, hole_tab[i], 16'h0000);
            chk8(u_mst.code, 8'h02);
            wr(hole_tab[i], 16'h0001, 8'h02);
        end
        for (int k = 0; k < 10; k++) begin
            rnd = lfsr(rnd);
            d = {10'h000, rnd[5:0]};
            ec = (d >= 16'h0001 && d <= 16'h001F) ? 8'h00 : 8'h03;
            wr(16'h1212, d, ec);
            chk16({11'h000, ANALOG_INPUT_FILTER}, shadow[16'h1212]);
        end
        $display("write checks done");
        // a refused write must not restart the wait
        wr(16'h1211, 16'h0001, 8'h00);
        chk8({7'h00, SETTINGS_SETTLED}, 8'h00);
        wr(16'h1211, 16'h0002, 8'h03);
        repeat (14) @(negedge CLK);
        chk8({7'h00, SETTINGS_SETTLED}, 8'h01);
        $display("settle check done");
        finish_test();
    end
endmodule
